// >>> flash_program_control.sv
/*
 Flash program control: control registers over AXI4-Lite, column latch buffer,
 launch unlock, space mapping of code reads and routing of data writes.
 Assumes core access ports and the flash array strobes share aclk.
*/
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`include "flash_program_control_defs.svh"
module flash_program_control
  import flash_program_control_pkg::*;
#(
  parameter int ERASE_CYCLES = `ERASE_CYCLES_DEF,
  parameter int PROG_CYCLES = `PROG_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [11:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic insn_retire,
  input wire logic data_wr_valid,
  input wire logic [15:0] data_wr_addr,
  input wire logic [7:0] data_wr_data,
  input wire logic [15:0] code_addr,
  output logic ext_wr_pulse,
  output logic [15:0] ext_wr_addr,
  output logic [7:0] ext_wr_data,
  output logic ext_wr_external,
  output code_space_t code_space,
  output logic arr_erase,
  output logic arr_prog,
  output logic [1:0] arr_space,
  output logic [14:0] arr_addr,
  output logic [7:0] arr_data
);
  latch_seq_if ls ();

  logic [7:0] flash_control_reg_reg, flash_control_reg_next;
  logic [7:0] aux_reg, aux_next;
  logic [7:0] aux_one_reg, aux_one_next;
  logic armed_reg, armed_next;
  logic busy_reg, busy_next;
  logic start_reg, start_next;
  logic [7:0] page_reg, page_next;
  logic [7:0] latch_mem [128];
  logic [127:0] loaded_reg;
  logic awready_reg, awready_next, wready_reg, wready_next;
  logic [11:0] aw_addr_reg, aw_addr_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next, arready_reg, arready_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_fire, latch_wr, flash_control_reg_wr;
  logic [3:0] launch_nib;
  logic [1:0] space_sel;
  logic addr_ok;
  logic ext_pulse_reg, ext_pulse_next, ext_external_reg, ext_external_next;
  logic [15:0] ext_addr_reg, ext_addr_next;
  logic [7:0] ext_data_reg, ext_data_next;
  code_space_t code_space_reg, code_space_next;

  assign s_axil_awready = awready_reg;
  assign s_axil_wready = wready_reg;
  assign s_axil_bvalid = bvalid_reg;
  assign s_axil_bresp = bresp_reg;
  assign s_axil_arready = arready_reg;
  assign s_axil_rvalid = rvalid_reg;
  assign s_axil_rdata = rdata_reg;
  assign s_axil_rresp = rresp_reg;
  assign ext_wr_pulse = ext_pulse_reg;
  assign ext_wr_addr = ext_addr_reg;
  assign ext_wr_data = ext_data_reg;
  assign ext_wr_external = ext_external_reg;
  assign code_space = code_space_reg;
  assign space_sel = flash_control_reg_reg[`SPACE_HI:`SPACE_LO];

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
  assign flash_control_reg_wr = wr_fire && (aw_addr_reg == `FLASH_CONTROL_OFS) && w_strb_reg[0];
  assign launch_nib = w_data_reg[`LAUNCH_HI:`LAUNCH_LO];

  always_comb begin
    awready_next = awready_reg;
    aw_addr_next = aw_addr_reg;
    wready_next = wready_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (s_axil_awvalid && awready_reg) begin
      awready_next = 1'b0;
      aw_addr_next = s_axil_awaddr;
    end
    if (s_axil_wvalid && wready_reg) begin
      wready_next = 1'b0;
      w_data_next = s_axil_wdata;
      w_strb_next = s_axil_wstrb;
    end
    if (wr_fire) begin
      awready_next = 1'b1;
      wready_next = 1'b1;
      bvalid_next = 1'b1;
      bresp_next = (aw_addr_reg == `FLASH_CONTROL_OFS || aw_addr_reg == `AUX_CONTROL_OFS ||
        aw_addr_reg == `AUX_CONTROL_ONE_OFS) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bvalid_reg && s_axil_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axil_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next = `RESP_OKAY;
      rdata_next = 32'h0000_0000;
      unique case (s_axil_araddr)
        `FLASH_CONTROL_OFS: rdata_next[7:0] = {flash_control_reg_reg[7:1], busy_reg};
        `AUX_CONTROL_OFS: rdata_next[7:0] = aux_reg;
        `AUX_CONTROL_ONE_OFS: rdata_next[7:0] = aux_one_reg;
        default: rresp_next = `RESP_SLVERR;
      endcase
    end else if (rvalid_reg && s_axil_rready) begin
      rvalid_next = 1'b0;
    end
    arready_next = !rvalid_next;
  end

  // ----------------------------------------
  // Control registers and launch
  // ----------------------------------------
  always_comb begin
    flash_control_reg_next = flash_control_reg_reg;
    aux_next = aux_reg;
    aux_one_next = aux_one_reg;
    armed_next = armed_reg;
    busy_next = busy_reg;
    start_next = 1'b0;
    if (insn_retire || latch_wr) begin
      armed_next = 1'b0;
    end
    if (flash_control_reg_wr) begin
      flash_control_reg_next = {w_data_reg[7:1], 1'b0};
      armed_next = 1'b0;
      if (!busy_reg) begin
        if (launch_nib == `LAUNCH_UNLOCK) begin
          armed_next = 1'b1;
        end else if (launch_nib == `LAUNCH_GO && armed_reg &&
            w_data_reg[`SPACE_HI:`SPACE_LO] != `SPACE_RSVD) begin
          start_next = 1'b1;
          busy_next = 1'b1;
        end
      end
    end
    if (wr_fire && aw_addr_reg == `AUX_CONTROL_OFS && w_strb_reg[0]) begin
      aux_next = w_data_reg[7:0];
    end
    if (wr_fire && aw_addr_reg == `AUX_CONTROL_ONE_OFS && w_strb_reg[0]) begin
      aux_one_next = w_data_reg[7:0];
    end
    if (ls.done) begin
      busy_next = 1'b0;
    end
  end

  // ----------------------------------------
  // Data writes and column latches
  // ----------------------------------------
  always_comb begin
    unique case (space_sel)
      `SPACE_EXTRA_ROW: addr_ok = data_wr_addr >= `EXTRA_ROW_BASE;
      `SPACE_SEC: addr_ok = data_wr_addr == `SEC_ADDR;
      default: addr_ok = data_wr_addr <= `USER_TOP;
    endcase
  end

  // Latch space only when mapped; the map wins over the external select
  assign latch_wr = data_wr_valid && flash_control_reg_reg[`LATCH_MAP_POS] && addr_ok && !busy_reg;

  always_comb begin
    page_next = page_reg;
    ext_pulse_next = 1'b0;
    ext_addr_next = ext_addr_reg;
    ext_data_next = ext_data_reg;
    ext_external_next = ext_external_reg;
    if (latch_wr) begin
      page_next = data_wr_addr[14:7];
    end else if (data_wr_valid && !flash_control_reg_reg[`LATCH_MAP_POS]) begin
      ext_pulse_next = 1'b1;
      ext_addr_next = data_wr_addr;
      ext_data_next = data_wr_data;
      ext_external_next = aux_reg[`EXT_DATA_POS];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 128; gi++) begin : g_latch
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          loaded_reg[gi] <= 1'b0;
          latch_mem[gi] <= 8'h00;
        end else if (latch_wr && data_wr_addr[6:0] == 7'(gi)) begin
          loaded_reg[gi] <= 1'b1;
          latch_mem[gi] <= data_wr_data;
        end else if (ls.done) begin
          loaded_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign ls.start = start_reg;
  assign ls.space = space_sel;
  assign ls.page = page_reg;
  assign ls.data = latch_mem[ls.idx];
  assign ls.loaded = loaded_reg[ls.idx];

  // ----------------------------------------
  // Code space decode
  // ----------------------------------------
  always_comb begin
    if (aux_one_reg[`BOOT_MAP_POS] && code_addr >= `BOOT_BASE) begin
      code_space_next = CODE_BOOT;
    end else if (space_sel == `SPACE_EXTRA_ROW && code_addr >= `EXTRA_ROW_BASE) begin
      code_space_next = CODE_EXTRA_ROW;
    end else if (space_sel == `SPACE_SEC && code_addr == `SEC_ADDR) begin
      code_space_next = CODE_SEC;
    end else if (code_addr <= `USER_TOP) begin
      code_space_next = CODE_USER;
    end else begin
      code_space_next = CODE_EXT;
    end
  end

  // ----------------------------------------
  // State registers
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flash_control_reg_reg <= `FLASH_CONTROL_RST;
      aux_reg <= `AUX_RST;
      aux_one_reg <= `AUX_RST;
      armed_reg <= 1'b0;
      busy_reg <= 1'b0;
      start_reg <= 1'b0;
      page_reg <= 8'h00;
      awready_reg <= 1'b1;
      aw_addr_reg <= 12'h000;
      wready_reg <= 1'b1;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
      rresp_reg <= `RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
      ext_pulse_reg <= 1'b0;
      ext_addr_reg <= 16'h0000;
      ext_data_reg <= 8'h00;
      ext_external_reg <= 1'b0;
      code_space_reg <= CODE_USER;
    end else begin
      flash_control_reg_reg <= flash_control_reg_next;
      aux_reg <= aux_next;
      aux_one_reg <= aux_one_next;
      armed_reg <= armed_next;
      busy_reg <= busy_next;
      start_reg <= start_next;
      page_reg <= page_next;
      awready_reg <= awready_next;
      aw_addr_reg <= aw_addr_next;
      wready_reg <= wready_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      arready_reg <= arready_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      ext_pulse_reg <= ext_pulse_next;
      ext_addr_reg <= ext_addr_next;
      ext_data_reg <= ext_data_next;
      ext_external_reg <= ext_external_next;
      code_space_reg <= code_space_next;
    end
  end

  flash_prog_sequencer #(
    .ERASE_CYCLES(ERASE_CYCLES),
    .PROG_CYCLES(PROG_CYCLES)
  ) u_seq (
    .aclk(aclk),
    .aresetn(aresetn),
    .ls(ls),
    .arr_erase(arr_erase),
    .arr_prog(arr_prog),
    .arr_space(arr_space),
    .arr_addr(arr_addr),
    .arr_data(arr_data)
  );
endmodule

// >>> flash_program_control_defs.svh
/*
 Offsets, field positions, reset values and counts of the flash program control.
 Assumes inclusion by bare name from the control and sequencer modules.
*/
`ifndef FLASH_PROGRAM_CONTROL_DEFS_SVH
`define FLASH_PROGRAM_CONTROL_DEFS_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FLASH_CONTROL_OFS 12'h000
`define AUX_CONTROL_OFS 12'h004
`define AUX_CONTROL_ONE_OFS 12'h008
// ----------------------------------------
// Fields
// ----------------------------------------
`define LAUNCH_HI 7
`define LAUNCH_LO 4
`define LATCH_MAP_POS 3
`define SPACE_HI 2
`define SPACE_LO 1
`define BUSY_POS 0
`define EXT_DATA_POS 1
`define BOOT_MAP_POS 0
`define FLASH_CONTROL_RST 8'h00
`define AUX_RST 8'h00
`define LAUNCH_UNLOCK 4'h5
`define LAUNCH_GO 4'hA
`define SPACE_USER 2'b00
`define SPACE_EXTRA_ROW 2'b01
`define SPACE_SEC 2'b10
`define SPACE_RSVD 2'b11
`define USER_TOP 16'h7FFF
`define EXTRA_ROW_BASE 16'hFF80
`define BOOT_BASE 16'hF800
`define SEC_ADDR 16'h0000
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`define ERASE_CYCLES_DEF 16
`define PROG_CYCLES_DEF 16
`endif

// >>> flash_program_control_pkg.sv
/*
 Types shared by the flash program control modules.
 Assumes the defs header sits in the same folder.
*/
package flash_program_control_pkg;
  typedef enum logic [2:0] {CODE_USER, CODE_EXTRA_ROW, CODE_SEC, CODE_BOOT, CODE_EXT} code_space_t;
  typedef enum logic [2:0] {SQ_IDLE, SQ_ERASE_SCAN, SQ_ERASE_WAIT, SQ_PROG_SCAN, SQ_PROG_WAIT,
    SQ_DONE} seq_state_t;
endpackage

// >>> latch_seq_if.sv
/*
 Carrier between the control register logic and the programming sequencer.
 Assumes both ends run on one clock.
*/
`timescale 1ns/1ns
interface latch_seq_if;
  logic start;
  logic [1:0] space;
  logic [7:0] page;
  logic [6:0] idx;
  logic [7:0] data;
  logic loaded;
  logic done;
  modport ctrl (output start, space, page, data, loaded, input idx, done);
  modport seq (input start, space, page, data, loaded, output idx, done);
endinterface

// >>> flash_prog_sequencer.sv
/*
 Erase-then-program sequencer over the loaded column latch entries.
 Assumes the control side holds latch contents stable while busy.
*/
`timescale 1ns/1ns
`include "flash_program_control_defs.svh"
module flash_prog_sequencer
  import flash_program_control_pkg::*;
#(
  parameter int ERASE_CYCLES = `ERASE_CYCLES_DEF,
  parameter int PROG_CYCLES = `PROG_CYCLES_DEF
) (
  input wire logic aclk,
  input wire logic aresetn,
  latch_seq_if.seq ls,
  output logic arr_erase,
  output logic arr_prog,
  output logic [1:0] arr_space,
  output logic [14:0] arr_addr,
  output logic [7:0] arr_data
);
  seq_state_t state_reg, state_next;
  logic [6:0] idx_reg, idx_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [1:0] space_reg, space_next;
  logic [7:0] page_reg, page_next;
  logic erase_reg, erase_next, prog_reg, prog_next, done_reg, done_next;
  logic [14:0] addr_reg, addr_next;
  logic [7:0] data_reg, data_next;

  assign ls.idx = idx_reg;
  assign ls.done = done_reg;
  assign arr_erase = erase_reg;
  assign arr_prog = prog_reg;
  assign arr_space = space_reg;
  assign arr_addr = addr_reg;
  assign arr_data = data_reg;

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    idx_next = idx_reg;
    cnt_next = cnt_reg;
    space_next = space_reg;
    page_next = page_reg;
    erase_next = 1'b0;
    prog_next = 1'b0;
    done_next = 1'b0;
    addr_next = addr_reg;
    data_next = data_reg;
    unique case (state_reg)
      SQ_IDLE: begin
        if (ls.start) begin
          space_next = ls.space;
          page_next = ls.page;
          idx_next = 7'h00;
          state_next = SQ_ERASE_SCAN;
        end
      end
      SQ_ERASE_SCAN, SQ_PROG_SCAN: begin
        if (ls.loaded) begin
          addr_next = {page_reg, idx_reg};
          data_next = ls.data;
          erase_next = (state_reg == SQ_ERASE_SCAN);
          prog_next = (state_reg == SQ_PROG_SCAN);
          cnt_next = (state_reg == SQ_ERASE_SCAN) ? 16'(ERASE_CYCLES - 1) : 16'(PROG_CYCLES - 1);
          state_next = (state_reg == SQ_ERASE_SCAN) ? SQ_ERASE_WAIT : SQ_PROG_WAIT;
        end else if (idx_reg == 7'h7F) begin
          idx_next = 7'h00;
          state_next = (state_reg == SQ_ERASE_SCAN) ? SQ_PROG_SCAN : SQ_DONE;
        end else begin
          idx_next = idx_reg + 7'h01;
        end
      end
      SQ_ERASE_WAIT, SQ_PROG_WAIT: begin
        if (cnt_reg == 16'h0000) begin
          if (idx_reg == 7'h7F) begin
            idx_next = 7'h00;
            state_next = (state_reg == SQ_ERASE_WAIT) ? SQ_PROG_SCAN : SQ_DONE;
          end else begin
            idx_next = idx_reg + 7'h01;
            state_next = (state_reg == SQ_ERASE_WAIT) ? SQ_ERASE_SCAN : SQ_PROG_SCAN;
          end
        end else begin
          cnt_next = cnt_reg - 16'h0001;
        end
      end
      SQ_DONE: begin
        done_next = 1'b1;
        state_next = SQ_IDLE;
      end
      default: state_next = SQ_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= SQ_IDLE;
      idx_reg <= 7'h00;
      cnt_reg <= 16'h0000;
      space_reg <= 2'b00;
      page_reg <= 8'h00;
      erase_reg <= 1'b0;
      prog_reg <= 1'b0;
      done_reg <= 1'b0;
      addr_reg <= 15'h0000;
      data_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      idx_reg <= idx_next;
      cnt_reg <= cnt_next;
      space_reg <= space_next;
      page_reg <= page_next;
      erase_reg <= erase_next;
      prog_reg <= prog_next;
      done_reg <= done_next;
      addr_reg <= addr_next;
      data_reg <= data_next;
    end
  end
endmodule

// >>> flash_program_control_sva.sv
/*
 Port checker for the flash program control.
 Assumes it is bound to the top module and shares its clock and reset.
*/
`timescale 1ns/1ns
module flash_program_control_sva #(
  parameter int ERASE_CYCLES = 2,
  parameter int PROG_CYCLES = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axil_awvalid,
  input wire logic s_axil_awready,
  input wire logic [1:0] s_axil_bresp,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic data_wr_valid,
  input wire logic [15:0] data_wr_addr,
  input wire logic ext_wr_pulse,
  input wire logic [15:0] ext_wr_addr,
  input wire logic arr_erase,
  input wire logic arr_prog
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_ar_taken;
    s_axil_arvalid && s_axil_arready;
  endsequence
  sequence s_b_waiting;
    s_axil_bvalid && !s_axil_bready;
  endsequence
  a_read_answered: assert property (s_ar_taken |=> s_axil_rvalid)
    else $error("read not answered");
  a_rdata_held: assert property (s_axil_rvalid && !s_axil_rready |=>
    s_axil_rvalid && $stable(s_axil_rdata)) else $error("read data dropped");
  a_bresp_held: assert property (s_b_waiting |=> s_axil_bvalid && $stable(s_axil_bresp))
    else $error("write response dropped");
  a_addr_refused: assert property (s_axil_awvalid && s_axil_awready |=> !s_axil_awready)
    else $error("address accepted twice");
  a_rdata_byte: assert property (s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  a_ext_forward: assert property (ext_wr_pulse |-> $past(data_wr_valid)
    && ext_wr_addr == $past(data_wr_addr)) else $error("forwarded write mismatch");
  a_erase_single: assert property (arr_erase |=> !arr_erase) else $error("erase twice");
  a_prog_single: assert property (arr_prog |=> !arr_prog) else $error("program twice");
  a_phase_apart: assert property (!(arr_erase && arr_prog)) else $error("erase with program");
endmodule
bind flash_program_control flash_program_control_sva #(.ERASE_CYCLES(ERASE_CYCLES),
  .PROG_CYCLES(PROG_CYCLES)) flash_program_control_sva_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axil_awvalid(s_axil_awvalid), .s_axil_awready(s_axil_awready),
  .s_axil_bresp(s_axil_bresp), .s_axil_bvalid(s_axil_bvalid), .s_axil_bready(s_axil_bready),
  .s_axil_arvalid(s_axil_arvalid), .s_axil_arready(s_axil_arready),
  .s_axil_rdata(s_axil_rdata), .s_axil_rvalid(s_axil_rvalid), .s_axil_rready(s_axil_rready),
  .data_wr_valid(data_wr_valid), .data_wr_addr(data_wr_addr), .ext_wr_pulse(ext_wr_pulse),
  .ext_wr_addr(ext_wr_addr), .arr_erase(arr_erase), .arr_prog(arr_prog));

// >>> core_model.sv
/*
 Processor core model: data-space writes, code reads, instruction retire.
 Assumes its tasks are called by the bench; interrupts are never raised.
*/
`timescale 1ns/1ns
module core_model (
  input wire logic aclk,
  output logic insn_retire,
  output logic data_wr_valid,
  output logic [15:0] data_wr_addr,
  output logic [7:0] data_wr_data,
  output logic [15:0] code_addr
);
  initial begin
    insn_retire = 1'b0;
    data_wr_valid = 1'b0;
    data_wr_addr = 16'hFFFF;
    data_wr_data = 8'h00;
    code_addr = 16'h0000;
  end
  // One data write, payload inverted once released
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge aclk);
    data_wr_valid <= 1'b1;
    data_wr_addr <= a;
    data_wr_data <= d;
    @(posedge aclk);
    data_wr_valid <= 1'b0;
    data_wr_addr <= ~a;
    data_wr_data <= ~d;
  endtask
  // Another instruction completes
  task automatic retire;
    @(posedge aclk);
    insn_retire <= 1'b1;
    @(posedge aclk);
    insn_retire <= 1'b0;
  endtask
  task automatic fetch(input logic [15:0] a);
    @(posedge aclk);
    code_addr <= a;
  endtask
endmodule

// >>> test_flash_program_control.sv
/*
 Self-checking bench for the flash program control.
 Assumes the core model and the bound checker compile beside it.
*/
`timescale 1ns/1ns
module test_flash_program_control;
  import flash_program_control_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, ext_pulse, ext_ext, erase, prog;
  logic retire, dvalid;
  logic [1:0] bresp, rresp, arr_space, r;
  logic [31:0] rdata, d;
  logic [15:0] daddr, caddr, ext_addr;
  logic [7:0] ddata, ext_data, arr_data, last_data;
  logic [14:0] arr_addr, last_addr;
  code_space_t code_space;
  int num_errors = 0, checked = 0, n_erase = 0, n_prog = 0, n_ext = 0, e0;
  always #50 aclk = ~aclk;
  always @(negedge aclk) begin
    if (erase) n_erase++;
    if (ext_pulse) n_ext++;
    if (prog) begin
      n_prog++;
      last_addr = arr_addr;
      last_data = arr_data;
    end
  end
  flash_program_control #(.ERASE_CYCLES(2), .PROG_CYCLES(2)) flash_program_control_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(wstrb),
    .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
    .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
    .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
    .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
    .insn_retire(retire), .data_wr_valid(dvalid), .data_wr_addr(daddr),
    .data_wr_data(ddata), .code_addr(caddr), .ext_wr_pulse(ext_pulse),
    .ext_wr_addr(ext_addr), .ext_wr_data(ext_data), .ext_wr_external(ext_ext),
    .code_space(code_space), .arr_erase(erase), .arr_prog(prog), .arr_space(arr_space),
    .arr_addr(arr_addr), .arr_data(arr_data));
  core_model core_model_inst (.aclk(aclk), .insn_retire(retire), .data_wr_valid(dvalid),
    .data_wr_addr(daddr), .data_wr_data(ddata), .code_addr(caddr));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("Comparisons %0d, mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] v);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h00_0000, v};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) begin
        bready <= 1'b0;
        return;
      end
    end
    check(32'h0000_0000, 32'h0000_0001);
    results();
  endtask
  task automatic axi_rd(input logic [11:0] a);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 60; n++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) begin
        rready <= 1'b0;
        return;
      end
    end
    check(32'h0000_0000, 32'h0000_0001);
    results();
  endtask
  task automatic launch(input logic [3:0] low, input logic busy);
    axi_wr(12'h000, {4'h5, low});
    axi_wr(12'h000, {4'hA, low});
    axi_rd(12'h000);
    check(d, {24'h00_0000, 4'hA, low[3:1], busy});
  endtask
  task automatic wait_idle;
    for (int n = 0; n < 200; n++) begin
      axi_rd(12'h000);
      if (d[0] === 1'b0) return;
    end
    check(d, 32'h0000_0000);
    results();
  endtask
  task automatic t_reset;
    axi_rd(12'h000);
    check(d, 32'h0000_0000);
    axi_rd(12'h00C);
    check(r, 2'b10);
    axi_wr(12'h00C, 8'hFF);
    check(r, 2'b10);
    axi_wr(12'h000, 8'h01);
    axi_rd(12'h000);
    check(d, 32'h0000_0000);
    $display("reset test done");
  endtask
  task automatic t_forward;
    e0 = n_ext;
    axi_wr(12'h004, 8'h02);
    core_model_inst.wr(16'h1234, 8'h5A);
    @(posedge aclk);
    check(n_ext - e0, 1);
    check({ext_addr, ext_data, 7'h00, ext_ext}, {16'h1234, 8'h5A, 8'h01});
    axi_wr(12'h000, 8'h08);
    core_model_inst.wr(16'h0010, 8'h11);
    @(posedge aclk);
    check(n_ext - e0, 1);
    $display("forward test done");
  endtask
  task automatic t_program;
    e0 = n_erase;
    core_model_inst.wr(16'h0105, 8'h22);
    core_model_inst.wr(16'h0283, 8'h33);
    launch(4'h8, 1'b1);
    wait_idle();
    check(n_erase - e0, 3);
    check({last_addr, last_data, arr_space}, {15'h0290, 8'h11, 2'b00});
    check(n_prog, n_erase);
    e0 = n_erase;
    launch(4'h8, 1'b1);
    core_model_inst.wr(16'h007F, 8'h77);
    wait_idle();
    check(n_erase - e0, 0);
    $display("program test done");
  endtask
  task automatic t_abort;
    e0 = n_erase;
    core_model_inst.wr(16'h0001, 8'h44);
    axi_wr(12'h000, 8'h58);
    core_model_inst.retire();
    axi_wr(12'h000, 8'hA8);
    axi_rd(12'h000);
    check(d, 32'h0000_00A8);
    axi_wr(12'h000, 8'hA8);
    axi_rd(12'h000);
    check(d, 32'h0000_00A8);
    check(n_erase - e0, 0);
    launch(4'h8, 1'b1);
    wait_idle();
    check(n_erase - e0, 1);
    $display("abort test done");
  endtask
  task automatic t_targets;
    launch(4'hE, 1'b0);
    axi_wr(12'h000, 8'h0A);
    core_model_inst.wr(16'hFF85, 8'h55);
    launch(4'hA, 1'b1);
    wait_idle();
    check({last_addr, arr_space}, {15'h7F85, 2'b01});
    axi_wr(12'h000, 8'h0C);
    core_model_inst.wr(16'h0000, 8'h66);
    launch(4'hC, 1'b1);
    wait_idle();
    check({last_data, arr_space}, {8'h66, 2'b10});
    $display("target test done");
  endtask
  task automatic t_space;
    logic [7:0] fc[5] = '{8'h02, 8'h04, 8'h00, 8'h00, 8'h00};
    logic [15:0] ad[5] = '{16'hFF80, 16'h0000, 16'h1000, 16'hF800, 16'h8000};
    code_space_t ex[5] = '{CODE_EXTRA_ROW, CODE_SEC, CODE_USER, CODE_BOOT, CODE_EXT};
    for (int i = 0; i < 5; i++) begin
      axi_wr(12'h000, fc[i]);
      axi_wr(12'h008, {7'h00, i == 3});
      core_model_inst.fetch(ad[i]);
      repeat (2) @(posedge aclk);
      check(code_space, ex[i]);
    end
    $display("space test done");
  endtask
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_forward();
    t_program();
    t_abort();
    t_targets();
    t_space();
    results();
  end
endmodule
